// ---- csa_pkg.sv ----
// shared constants, select encodings and carrier structs for the cascaded alu
// assumes: compiled before every other file of the block
package csa_pkg;

  localparam int CSA_SLICE_W = 4;
  localparam int CSA_LOOK_SLICES = 4;
  localparam int CSA_EXT_SLICES = 3;
  localparam int CSA_EXT_BLOCKS = 0;
  localparam int CSA_ONES_FIRST_MAX = 3;
  localparam int CSA_EXT_GATE_DELAYS = 2;
  localparam int CSA_SM_WIDTH = 5;
  localparam int CSA_OUT_LATENCY = 1;
  localparam logic CSA_FLAG_RESET = 1'b0;

  typedef enum logic [1:0] {
    CSA_TWOS,
    CSA_ONES,
    CSA_SIGN_MAG
  } csa_repr_t;

  typedef enum logic [1:0] {
    CSA_FN_SUB,
    CSA_FN_ADD,
    CSA_FN_XOR,
    CSA_FN_AND
  } csa_fn_t;

  typedef struct packed {
    csa_repr_t repr;
    logic polarity_high;
    logic function_select_low;
    logic function_select_high;
    logic carry_remove;
  } csa_ctrl_t;

  typedef struct packed {
    logic carry_out;
    logic ge;
    logic gt;
    logic eq_compare;
    logic eq_word;
    logic block_carry_generate;
    logic block_carry_propagate;
    logic negative_fixup;
  } csa_flags_t;

  localparam csa_flags_t CSA_FLAGS_RESET = '{default: CSA_FLAG_RESET};

  // select lines are pin levels; same decode for every polarity once operands are logical
  function automatic csa_fn_t csa_decode(input logic function_select_low, input logic function_select_high);
    case ({function_select_high, function_select_low})
      2'b00: csa_decode = CSA_FN_SUB;
      2'b01: csa_decode = CSA_FN_ADD;
      2'b10: csa_decode = CSA_FN_XOR;
      default: csa_decode = CSA_FN_AND;
    endcase
  endfunction : csa_decode

endpackage : csa_pkg

// ---- csa_slice.sv ----
// one 4-bit alu slice with block carry generate and propagate
// assumes: operands already in logical (true) form; carry in is settled by the caller
`timescale 1ns/100ps
module csa_slice
  import csa_pkg::*;
(
  input wire logic [CSA_SLICE_W-1:0] a,
  input wire logic [CSA_SLICE_W-1:0] b,
  input wire logic function_select_low,
  input wire logic function_select_high,
  input wire logic carry_in,
  input wire logic carry_out_enable,
  output logic [CSA_SLICE_W-1:0] f,
  output logic block_carry_generate,
  output logic block_carry_propagate,
  output logic carry_out,
  output logic equal
);

  wire csa_fn_t fn = csa_decode(function_select_low, function_select_high);
  wire logic invert_b = (fn == CSA_FN_SUB) || (fn == CSA_FN_XOR);
  wire logic [CSA_SLICE_W-1:0] b_eff = invert_b ? ~b : b;
  wire logic [CSA_SLICE_W-1:0] gen = a & b_eff;
  wire logic [CSA_SLICE_W-1:0] prop = (fn == CSA_FN_AND) ? {CSA_SLICE_W{1'b1}} : (a | b_eff);
  logic [CSA_SLICE_W:0] c;

  // internal lookahead; high select forces every internal carry
  always_comb begin
    c[0] = function_select_high | carry_in;
    for (int i = 0; i < CSA_SLICE_W; i++) begin
      c[i+1] = function_select_high | gen[i] | (prop[i] & c[i]);
    end
  end

  // generate is built from operands and selects only, so no path from carry in reaches it
  always_comb begin
    block_carry_generate = gen[3] | (prop[3] & gen[2]) | (&prop[3:2] & gen[1]) | (&prop[3:1] & gen[0]);
  end

  assign block_carry_propagate = &prop;
  assign carry_out = block_carry_generate | (block_carry_propagate & carry_in & carry_out_enable);
  assign f = (~gen & prop) ^ c[CSA_SLICE_W-1:0];
  assign equal = block_carry_propagate & ~block_carry_generate;

endmodule : csa_slice

// ---- csa_alu.sv ----
// cascaded signed alu: 16-bit base section plus optional 12-bit blocks, carries rippled slice to slice
// assumes: operands and controls come from logic on mclk; outputs are one register stage late
`timescale 1ns/100ps
module csa_alu
  import csa_pkg::*;
#(
  parameter int EXT_BLOCKS = CSA_EXT_BLOCKS,
  parameter int NS = CSA_LOOK_SLICES + CSA_EXT_SLICES * EXT_BLOCKS,
  parameter int W = CSA_SLICE_W * NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire csa_ctrl_t ctrl,
  input wire logic [W-1:0] operand_a,
  input wire logic [W-1:0] operand_b,
  output logic [W-1:0] result,
  output csa_flags_t flags
);

  // pins to logical values; active-low words are simply inverted
  wire logic [W-1:0] a_l = ctrl.polarity_high ? operand_a : ~operand_a;
  wire logic [W-1:0] b_l = ctrl.polarity_high ? operand_b : ~operand_b;
  wire csa_fn_t fn = csa_decode(ctrl.function_select_low, ctrl.function_select_high);
  wire logic is_sm = (ctrl.repr == CSA_SIGN_MAG);
  wire logic is_ones = (ctrl.repr == CSA_ONES);

  // sign-magnitude: signs handled here, magnitudes zero-padded at the top
  wire logic sign_a = a_l[W-1];
  wire logic sign_b = b_l[W-1];
  wire logic eff_sub = sign_a ^ sign_b ^ (fn == CSA_FN_SUB);
  wire logic [W-1:0] row1_a = is_sm ? {1'b0, a_l[W-2:0]} : a_l;
  wire logic [W-1:0] row1_b = is_sm ? {1'b0, b_l[W-2:0]} : b_l;
  wire logic row1_s0 = is_sm ? ~eff_sub : ctrl.function_select_low;
  wire logic row1_s1 = is_sm ? 1'b0 : ctrl.function_select_high;

  // lowest carry pin follows the low select; active-high adds an inverter
  wire logic lowest_carry_generate_input = ctrl.polarity_high ? ~ctrl.function_select_low
                                                              : ctrl.function_select_low;
  wire logic lowest_active_carry = ctrl.polarity_high ? lowest_carry_generate_input
                                                      : ~lowest_carry_generate_input;
  wire logic forced_carry = lowest_active_carry & ~ctrl.carry_remove;

  logic [W-1:0] row1_f;
  logic [W-1:0] row2_f;
  logic [NS-1:0] g1, p1, e1, co1, cin1;
  logic [NS-1:0] g2, p2, e2, co2, cin2;
  logic word_g, word_p, end_around, row1_cin, row1_cout, row2_cout;

  // carry distribution: slice-to-slice ripple through every slice, 16-bit section and 12-bit blocks alike
  function automatic logic [NS:0] csa_carries(input logic [NS-1:0] g, input logic [NS-1:0] p, input logic c0);
    logic [NS:0] c;
    c = '0;
    c[0] = c0;
    for (int i = 0; i < NS; i++) begin
      c[i+1] = g[i] | (p[i] & c[i]);
    end
    csa_carries = c;
  endfunction : csa_carries

  // word generate with zero carry in; carry out then needs no feedback loop
  logic [NS:0] word_c;
  assign word_c = csa_carries(g1, p1, 1'b0);
  assign word_g = word_c[NS];
  assign word_p = &p1;
  // end-around: top carry with the loop cut is the word generate itself
  assign end_around = word_g;
  // in ones' complement, forced carry only matters when the whole word propagates; it turns minus zero into zero
  assign row1_cin = is_sm ? eff_sub : (is_ones ? (end_around | (forced_carry & word_p)) : forced_carry);

  always_comb begin
    logic [NS:0] c;
    c = csa_carries(g1, p1, row1_cin);
    cin1 = c[NS-1:0];
  end

  always_comb begin
    logic [NS:0] c;
    c = csa_carries(g2, p2, 1'b1);
    cin2 = c[NS-1:0];
  end

  // row1: base slices 0..3, then 12-bit blocks stacked above them
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_row
      csa_slice u_row1 (
        .a(row1_a[gi*CSA_SLICE_W +: CSA_SLICE_W]),
        .b(row1_b[gi*CSA_SLICE_W +: CSA_SLICE_W]),
        .function_select_low(row1_s0),
        .function_select_high(row1_s1),
        .carry_in(cin1[gi]),
        .carry_out_enable(gi == NS-1),
        .f(row1_f[gi*CSA_SLICE_W +: CSA_SLICE_W]),
        .block_carry_generate(g1[gi]),
        .block_carry_propagate(p1[gi]),
        .carry_out(co1[gi]),
        .equal(e1[gi])
      );
      // row2 computes zero minus row1 result
      csa_slice u_row2 (
        .a({CSA_SLICE_W{1'b0}}),
        .b(row1_f[gi*CSA_SLICE_W +: CSA_SLICE_W]),
        .function_select_low(1'b0),
        .function_select_high(1'b0),
        .carry_in(cin2[gi]),
        .carry_out_enable(gi == NS-1),
        .f(row2_f[gi*CSA_SLICE_W +: CSA_SLICE_W]),
        .block_carry_generate(g2[gi]),
        .block_carry_propagate(p2[gi]),
        .carry_out(co2[gi]),
        .equal(e2[gi])
      );
    end
  endgenerate

  assign row1_cout = co1[NS-1];
  assign row2_cout = co2[NS-1];

  // negative magnitude difference shows as no carry out of the subtract
  wire logic sm_negative = is_sm & eff_sub & ~row1_cout;
  wire logic [W-2:0] sm_mag = sm_negative ? row2_f[W-2:0] : row1_f[W-2:0];
  wire logic sm_sign = sm_negative ? ~sign_a : sign_a;
  wire logic [W-1:0] logical_result = is_sm ? {sm_sign, sm_mag} : row1_f;
  // sign-magnitude overflow lands in the padded top magnitude bit
  wire logic next_carry = is_sm ? (~eff_sub & row1_f[W-1]) : row1_cout;

  // comparison from one subtract: with carry in gives a>=b, without gives a>b
  wire logic next_ge = word_g | word_p;
  wire logic next_gt = word_g;
  wire logic next_eq_compare = next_ge & ~next_gt;
  wire logic next_eq_word = &e1;
  wire logic [W-1:0] next_result = ctrl.polarity_high ? logical_result : ~logical_result;

  wire csa_flags_t next_flags = '{
    carry_out: next_carry,
    ge: next_ge,
    gt: next_gt,
    eq_compare: next_eq_compare,
    eq_word: next_eq_word,
    block_carry_generate: word_g,
    block_carry_propagate: word_p,
    negative_fixup: sm_negative
  };

  // output register stage, always present: the datapath above has no state of its own
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result <= '0;
      flags <= CSA_FLAGS_RESET;
    end else if (clk_en) begin
      result <= next_result;
      flags <= next_flags;
    end
  end

  logic unused_row2;
  assign unused_row2 = row2_cout ^ (^g2) ^ (^p2) ^ (^e2);

endmodule : csa_alu

// ---- csa_alu_asserts.sv ----
// port checks for the cascaded alu, active high operands
// assumes: bound to csa_alu; outputs land one enabled edge late
`timescale 1ns/100ps
module csa_alu_asserts
  import csa_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire csa_ctrl_t ctrl,
  input wire logic [W-1:0] operand_a,
  input wire logic [W-1:0] operand_b,
  input wire logic [W-1:0] result,
  input wire csa_flags_t flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire tw = clk_en && ctrl.repr == CSA_TWOS && ctrl.polarity_high;
  wire [1:0] sel = {ctrl.function_select_high, ctrl.function_select_low};
  wire [W:0] raw = {1'b0, operand_a} + operand_b;
  wire [W-1:0] diff = operand_a - operand_b;
  wire [W-1:0] diff_less = operand_a - operand_b - 1'b1;
  // a plus inverted b plus one, carry kept in the top bit
  wire [W:0] sub_raw = {1'b0, operand_a} + {1'b0, ~operand_b} + 1'b1;
  // end-around carry folded back into bit 0
  wire [W-1:0] ones_add = raw[W-1:0] + raw[W];
  sequence s_sub;
    tw && sel == 2'b00;
  endsequence
  sequence s_sub_full;
    s_sub ##0 !ctrl.carry_remove;
  endsequence
  chk_ge_flag: assert property (s_sub |=> flags.ge == $past(operand_a >= operand_b))
    else $error("ge flag wrong");
  chk_gt_flag: assert property (s_sub |=> flags.gt == $past(operand_a > operand_b))
    else $error("gt flag wrong");
  chk_eq_split: assert property (s_sub |=> flags.eq_compare == $past(operand_a == operand_b))
    else $error("equal flag wrong");
  chk_word_equal: assert property (tw && !sel[0] |=> flags.eq_word == $past(operand_a == operand_b))
    else $error("word equal wrong");
  chk_sub_value: assert property (s_sub_full |=> result == $past(diff) && flags.carry_out == $past(sub_raw[W])
    && flags.carry_out == $past(operand_a >= operand_b))
    else $error("subtract wrong");
  chk_sub_less: assert property (s_sub ##0 ctrl.carry_remove |=> result == $past(diff_less))
    else $error("subtract without carry wrong");
  chk_add_value: assert property (tw && sel == 2'b01 |=> {flags.carry_out, result} == $past(raw))
    else $error("add wrong");
  chk_logic_ops: assert property (tw && sel[1] |=> result == $past(sel[0] ? operand_a & operand_b : operand_a ^ operand_b))
    else $error("logic function wrong");
  chk_ones_wrap: assert property (clk_en && ctrl.repr == CSA_ONES && ctrl.polarity_high && sel == 2'b01
    && (operand_a ^ operand_b) != '1 |=> result == $past(ones_add))
    else $error("ones add wrong");
  chk_hold_idle: assert property (!clk_en |=> $stable(result) && $stable(flags))
    else $error("outputs moved while disabled");
endmodule : csa_alu_asserts

bind csa_alu csa_alu_asserts #(.W(W)) u_chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ctrl(ctrl),
  .operand_a(operand_a), .operand_b(operand_b), .result(result), .flags(flags));

// ---- csa_feed.sv ----
// datapath control model: selects, carry control and operand pins
// assumes: caller gives true-logic operands; pins follow the chosen polarity
`timescale 1ns/100ps
module csa_feed
  import csa_pkg::*;
#(
  parameter int W = 16
) (
  input wire csa_repr_t repr,
  input wire csa_fn_t fn,
  input wire logic pol_high,
  input wire logic carry_remove,
  input wire logic [W-1:0] a_true,
  input wire logic [W-1:0] b_true,
  output csa_ctrl_t ctrl,
  output logic [W-1:0] a_pin,
  output logic [W-1:0] b_pin
);
  wire [1:0] fn_code = fn;
  assign ctrl = '{repr, pol_high, fn_code[0], fn_code[1], carry_remove};
  // active low operands leave here inverted
  assign a_pin = pol_high ? a_true : ~a_true;
  assign b_pin = pol_high ? b_true : ~b_true;
endmodule : csa_feed

// ---- test_cascaded_signed_alu_compare.sv ----
// self-checking bench for the cascaded alu with one 12-bit extension block
// assumes: csa_pkg, csa_feed, the alu and its checker compiled first
`timescale 1ns/100ps
module test_cascaded_signed_alu_compare
  import csa_pkg::*;
;
  localparam int W = 28;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b0;
  csa_repr_t repr = CSA_TWOS;
  csa_fn_t fn = CSA_FN_SUB;
  logic pol_high = 1'b1;
  logic carry_remove = 1'b0;
  logic [W-1:0] a_true = '0;
  logic [W-1:0] b_true = '0;
  csa_ctrl_t ctrl;
  logic [W-1:0] a_pin;
  logic [W-1:0] b_pin;
  logic [W-1:0] result;
  csa_flags_t flags;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [W-1:0] pa [5] = '{28'h0000005, 28'h0000003, 28'h0000007, 28'h8000000, 28'h0000010};
  logic [W-1:0] pb [5] = '{28'h0000003, 28'h0000005, 28'h0000007, 28'h0000001, 28'h1000010};

  always #2 mclk = ~mclk;

  csa_feed #(.W(W)) feed (.repr(repr), .fn(fn), .pol_high(pol_high), .carry_remove(carry_remove),
    .a_true(a_true), .b_true(b_true), .ctrl(ctrl), .a_pin(a_pin), .b_pin(b_pin));
  csa_alu #(.EXT_BLOCKS(1)) dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ctrl(ctrl),
    .operand_a(a_pin), .operand_b(b_pin), .result(result), .flags(flags));

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [W:0] seen, input logic [W:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one enabled edge, then look at the settled outputs
  task automatic run(input csa_repr_t r, input csa_fn_t f, input logic cr, input logic [W-1:0] a,
    input logic [W-1:0] b);
    @(negedge mclk);
    repr = r;
    fn = f;
    carry_remove = cr;
    a_true = a;
    b_true = b;
    clk_en = 1'b1;
    @(negedge mclk);
  endtask : run

  function automatic logic [W-1:0] sm(input logic s, input logic [3:0] m);
    sm = {s, {(W-5){1'b0}}, m};
  endfunction : sm

  task automatic t_compare();
    for (int i = 0; i < 5; i++) begin
      run(CSA_TWOS, CSA_FN_SUB, 1'b0, pa[i], pb[i]);
      check({flags.carry_out, result}, {pa[i] >= pb[i], pa[i] - pb[i]});
      check({flags.ge, flags.gt, flags.eq_compare, flags.eq_word},
        {pa[i] >= pb[i], pa[i] > pb[i], pa[i] == pb[i], pa[i] == pb[i]});
      check({flags.block_carry_generate, flags.block_carry_propagate}, {pa[i] > pb[i], &(pa[i] | ~pb[i])});
      run(CSA_TWOS, CSA_FN_SUB, 1'b1, pa[i], pb[i]);
      check({flags.carry_out, result}, {pa[i] > pb[i], pa[i] - pb[i] - 1'b1});
    end
  endtask : t_compare

  task automatic t_functions();
    logic [W-1:0] fa = 28'h0f0a5c3;
    logic [W-1:0] fb = 28'h0ff0912;
    logic [W-1:0] e [4] = '{fa - fb, fa + fb, fa ^ fb, fa & fb};
    for (int f = 0; f < 4; f++) begin
      run(CSA_TWOS, csa_fn_t'(f), 1'b0, fa, fb);
      check(result, e[f]);
    end
    run(CSA_TWOS, CSA_FN_ADD, 1'b0, 28'hfffffff, 28'h0000001);
    check({flags.carry_out, result}, {1'b1, 28'h0000000});
  endtask : t_functions

  task automatic t_active_low();
    pol_high = 1'b0;
    run(CSA_TWOS, CSA_FN_ADD, 1'b0, 28'h0000005, 28'h0000003);
    check(result, {~28'h0000008});
    run(CSA_TWOS, CSA_FN_SUB, 1'b0, 28'h0000009, 28'h0000004);
    check({flags.ge, result}, {1'b1, ~28'h0000005});
    pol_high = 1'b1;
  endtask : t_active_low

  task automatic t_ones();
    run(CSA_ONES, CSA_FN_ADD, 1'b0, 28'h0000005, ~28'h0000003);
    check(result, 28'h0000002);
    run(CSA_ONES, CSA_FN_SUB, 1'b0, 28'h0000003, 28'h0000005);
    check(result, {~28'h0000002});
  endtask : t_ones

  task automatic sm_case(input csa_fn_t f, input logic sa, input logic [3:0] ma, input logic sb,
    input logic [3:0] mb, input logic fix, input logic sr, input logic [3:0] mr);
    run(CSA_SIGN_MAG, f, 1'b0, sm(sa, ma), sm(sb, mb));
    check({flags.negative_fixup, result}, {fix, sm(sr, mr)});
  endtask : sm_case

  task automatic t_hold();
    run(CSA_TWOS, CSA_FN_ADD, 1'b0, 28'h0000001, 28'h0000002);
    clk_en = 1'b0;
    a_true = 28'h0000007;
    @(negedge mclk);
    check(result, 28'h0000003);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    check({|flags, result}, '0);
  endtask : t_hold

  // ceiling well above the roughly 66 cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    t_compare();
    t_functions();
    t_active_low();
    t_ones();
    sm_case(CSA_FN_ADD, 1'b0, 4'h5, 1'b1, 4'h3, 1'b0, 1'b0, 4'h2);
    sm_case(CSA_FN_ADD, 1'b0, 4'h3, 1'b1, 4'h5, 1'b1, 1'b1, 4'h2);
    sm_case(CSA_FN_SUB, 1'b0, 4'h3, 1'b0, 4'h5, 1'b1, 1'b1, 4'h2);
    sm_case(CSA_FN_ADD, 1'b1, 4'h4, 1'b1, 4'h6, 1'b0, 1'b1, 4'ha);
    t_hold();
    end_sim();
  end
endmodule : test_cascaded_signed_alu_compare
